/* File: shared/adio_regs.svh */
// register offsets, function codes, reset values and timing constants
`ifndef ADIO_REGS_SVH
`define ADIO_REGS_SVH

// byte offsets on the register bus
`define ADIO_OFS_IN_LO     8'h00
`define ADIO_OFS_IN_HI     8'h04
`define ADIO_OFS_OUT_LO    8'h08
`define ADIO_OFS_OUT_HI    8'h0c
`define ADIO_OFS_STATUS    8'h10
`define ADIO_OFS_REMOTE    8'h14
`define ADIO_OFS_LINK_ERR  8'h18
`define ADIO_OFS_LAST      8'h18

// input function codes
`define ADIO_FN_HOME       8'h03
`define ADIO_FN_START      8'h04
`define ADIO_FN_FREE       8'h10
`define ADIO_FN_STOP       8'h12
`define ADIO_FN_FCLR       8'h18
`define ADIO_FN_SEL0       8'h30
`define ADIO_FN_SEL1       8'h31
`define ADIO_FN_SEL2       8'h32

// output function codes
`define ADIO_FN_FAULT      8'h41
`define ADIO_FN_CAUTION    8'h42
`define ADIO_FN_READY      8'h43
`define ADIO_FN_END        8'h45
`define ADIO_FN_HOME_POS   8'h46
`define ADIO_FN_ZONE1      8'h49

// terminal reset assignments, terminal 0 first
`define ADIO_IN_DEFAULTS   '{8'h03, 8'h04, 8'h30, 8'h31, 8'h32, 8'h10, 8'h12, 8'h18}
`define ADIO_OUT_DEFAULTS  '{8'h46, 8'h45, 8'h49, 8'h43, 8'h42, 8'h41}

// switch reset values and baud table
`define ADIO_RATE_FACTORY  4'h7
`define ADIO_BAUD_0        20'd9600
`define ADIO_BAUD_1        20'd19200
`define ADIO_BAUD_2        20'd38400
`define ADIO_BAUD_3        20'd57600
`define ADIO_BAUD_4        20'd115200
`define ADIO_BAUD_7        20'd625000

// timing
`define ADIO_CLK_KHZ       20000
`define ADIO_BLINK_MS      250

`endif

/* File: shared/adio_pkg.sv */
// types shared by the terminal mapping block
package adio_pkg;
  typedef logic [7:0] adio_code_t;
  typedef enum logic {
    ADIO_PROTO_CONVERTER = 1'b0,
    ADIO_PROTO_MODBUS    = 1'b1
  } adio_proto_t;
  typedef enum logic [1:0] {
    ADIO_RESP_OKAY   = 2'b00,
    ADIO_RESP_SLVERR = 2'b10
  } adio_resp_t;
endpackage

/* File: verilog/adio_top.sv */
// terminal function mapping, switch decode and indicators
`timescale 1ns/10ps
`include "adio_regs.svh"

module adio_top
#(
  parameter int unsigned BLINK_HALF_CYC = `ADIO_BLINK_MS * `ADIO_CLK_KHZ
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output adio_pkg::adio_resp_t      bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output adio_pkg::adio_resp_t      rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [7:0]           input_terminal,
  output logic [5:0]                output_terminal,
  input  wire logic [3:0]           axis_rotary_switch,
  input  wire logic [3:0]           rate_select_switch,
  input  wire logic [1:0]           function_dip_switch,
  input  wire logic                 home_position,
  input  wire logic                 move_done,
  input  wire logic                 moving_state,
  input  wire logic                 ready_state,
  input  wire logic                 zone_one_flag,
  input  wire logic                 zone_two_flag,
  input  wire logic                 zone_three_flag,
  input  wire logic                 caution_output,
  input  wire logic                 fault_output,
  input  wire logic                 torque_limit_output,
  input  wire logic                 step_timing_output,
  input  wire logic                 serial_busy_output,
  input  wire logic                 limit_pos_sensor,
  input  wire logic                 limit_neg_sensor,
  input  wire logic                 home_sensor,
  input  wire logic                 slit_sensor,
  input  wire logic                 rx_active,
  input  wire logic                 tx_active,
  input  wire logic                 comm_error_event,
  output logic                      home_req,
  output logic                      start_req,
  output logic                      data_select_bit0,
  output logic                      data_select_bit1,
  output logic                      data_select_bit2,
  output logic [2:0]                data_select_high,
  output logic                      motor_free,
  output logic                      halt_req,
  output logic                      fault_clear,
  output logic [53:0]               input_function_levels,
  output logic [4:0]                axis_number,
  output logic [3:0]                rate_code,
  output logic [19:0]               baud_rate,
  output logic                      rate_valid,
  output adio_pkg::adio_proto_t     protocol,
  output logic                      supply_lamp,
  output logic                      fault_lamp,
  output logic                      link_activity_lamp,
  output logic                      link_error_lamp
);
  import adio_pkg::*;

  localparam adio_code_t IN_DEF  [8] = `ADIO_IN_DEFAULTS;
  localparam adio_code_t OUT_DEF [6] = `ADIO_OUT_DEFAULTS;
  localparam logic [22:0] BLINK_LAST = 23'(BLINK_HALF_CYC - 1);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  adio_code_t  in_code  [8];
  adio_code_t  out_code [6];
  logic [15:0] remote_bits;
  logic        link_err;
  logic        cfg_taken;
  logic [22:0] blink_cnt;
  logic        home_q;
  logic        start_q;
  logic        fclr_q;

  // write channel: address and data may arrive in either order
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  wire         aw_take     = awvalid & awready;
  wire         w_take      = wvalid & wready;
  wire         have_aw     = aw_full | aw_take;
  wire         have_w      = w_full | w_take;
  wire         do_write    = have_aw & have_w & ~bvalid;
  wire         next_bvalid = do_write | (bvalid & ~bready);
  wire [7:0]   wr_addr     = aw_take ? awaddr : aw_addr_q;
  wire [31:0]  wr_data     = w_take ? wdata : w_data_q;
  wire [3:0]   wr_strb     = w_take ? wstrb : w_strb_q;
  wire [7:0]   wr_word     = {wr_addr[7:2], 2'b00};
  wire         wr_mapped   = wr_word <= `ADIO_OFS_LAST;
  wire         wr_remote   = do_write & (wr_word == `ADIO_OFS_REMOTE);
  wire         wr_err_clr  = do_write & (wr_word == `ADIO_OFS_LINK_ERR)
                             & wr_strb[0] & wr_data[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= ADIO_RESP_OKAY;
      awready   <= 1'b0;
      wready    <= 1'b0;
    end
    else
    begin
      aw_full <= have_aw & ~do_write;
      w_full  <= have_w & ~do_write;
      if (aw_take)
        aw_addr_q <= awaddr;
      if (w_take)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      bvalid  <= next_bvalid;
      awready <= ~(have_aw & ~do_write) & ~next_bvalid;
      wready  <= ~(have_w & ~do_write) & ~next_bvalid;
      if (do_write)
        bresp <= wr_mapped ? ADIO_RESP_OKAY : ADIO_RESP_SLVERR;
    end
  end

  // read channel
  wire         rd_take     = arvalid & arready;
  wire         next_rvalid = rd_take | (rvalid & ~rready);
  wire [7:0]   rd_word     = {araddr[7:2], 2'b00};
  wire [31:0]  status_word = {5'h00, fault_output, link_err, protocol,
                              rate_valid, rate_code, axis_number,
                              output_terminal, input_terminal};
  wire [31:0]  rd_data =
    (rd_word == `ADIO_OFS_IN_LO)    ?
      {in_code[3], in_code[2], in_code[1], in_code[0]} :
    (rd_word == `ADIO_OFS_IN_HI)    ?
      {in_code[7], in_code[6], in_code[5], in_code[4]} :
    (rd_word == `ADIO_OFS_OUT_LO)   ?
      {out_code[3], out_code[2], out_code[1], out_code[0]} :
    (rd_word == `ADIO_OFS_OUT_HI)   ? {16'h0000, out_code[5], out_code[4]} :
    (rd_word == `ADIO_OFS_STATUS)   ? status_word :
    (rd_word == `ADIO_OFS_REMOTE)   ? {16'h0000, remote_bits} :
    (rd_word == `ADIO_OFS_LINK_ERR) ? {31'h0000_0000, link_err} :
    32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ADIO_RESP_OKAY;
    end
    else
    begin
      rvalid  <= next_rvalid;
      arready <= ~next_rvalid;
      if (rd_take)
      begin
        rdata <= rd_data;
        rresp <= (rd_word <= `ADIO_OFS_LAST) ? ADIO_RESP_OKAY
                                             : ADIO_RESP_SLVERR;
      end
    end
  end

  // function code storage, one byte lane per terminal
  genvar t;
  generate
    for (t = 0; t < 8; t++)
    begin : g_in_code
      wire sel = do_write & wr_strb[t % 4]
                 & (wr_word == 8'(`ADIO_OFS_IN_LO + 4 * (t / 4)));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          in_code[t] <= IN_DEF[t];
        else if (sel)
          in_code[t] <= wr_data[8 * (t % 4) +: 8];
      end
    end
    for (t = 0; t < 6; t++)
    begin : g_out_code
      wire sel = do_write & wr_strb[t % 4]
                 & (wr_word == 8'(`ADIO_OFS_OUT_LO + 4 * (t / 4)));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          out_code[t] <= OUT_DEF[t];
        else if (sel)
          out_code[t] <= wr_data[8 * (t % 4) +: 8];
      end
    end
  endgenerate

  // several terminals may share one function; any of them asserts it
  logic [53:0] func_in;
  assign func_in[0] = 1'b0;
  genvar f;
  generate
    for (f = 1; f < 54; f++)
    begin : g_func
      wire [7:0] hits;
      for (t = 0; t < 8; t++)
      begin : g_hit
        assign hits[t] = input_terminal[t]
                         & (in_code[t] == 8'(f));
      end
      assign func_in[f] = |hits;
    end
  endgenerate

  // requests toward the motion core; home, start and fault clear fire on the rising edge, the rest follow the level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      home_q                <= 1'b0;
      start_q               <= 1'b0;
      fclr_q                <= 1'b0;
      home_req              <= 1'b0;
      start_req             <= 1'b0;
      fault_clear           <= 1'b0;
      data_select_bit0      <= 1'b0;
      data_select_bit1      <= 1'b0;
      data_select_bit2      <= 1'b0;
      data_select_high      <= 3'h0;
      motor_free            <= 1'b0;
      halt_req              <= 1'b0;
      input_function_levels <= 54'h0;
    end
    else
    begin
      home_q                <= func_in[3];
      start_q               <= func_in[4];
      fclr_q                <= func_in[24];
      home_req              <= func_in[3] & ~home_q;
      start_req             <= func_in[4] & ~start_q;
      fault_clear           <= func_in[24] & ~fclr_q;
      data_select_bit0      <= func_in[48];
      data_select_bit1      <= func_in[49];
      data_select_bit2      <= func_in[50];
      data_select_high      <= func_in[53:51];
      motor_free            <= func_in[16];
      halt_req              <= func_in[18];
      input_function_levels <= func_in;
    end
  end

  // output function sources, indexed by code
  wire [127:0] out_src;
  assign out_src[0]      = 1'b0;
  assign out_src[18:1]   = func_in[18:1];
  assign out_src[31:19]  = 13'h0000;
  assign out_src[47:32]  = remote_bits;
  assign out_src[53:48]  = func_in[53:48];
  assign out_src[59:54]  = 6'h00;
  assign out_src[60]     = limit_pos_sensor;
  assign out_src[61]     = limit_neg_sensor;
  assign out_src[62]     = home_sensor;
  assign out_src[63]     = slit_sensor;
  assign out_src[64]     = 1'b0;
  assign out_src[65]     = ~fault_output;
  assign out_src[66]     = caution_output;
  assign out_src[67]     = ready_state;
  assign out_src[68]     = moving_state;
  assign out_src[69]     = move_done;
  assign out_src[70]     = home_position;
  assign out_src[71]     = torque_limit_output;
  assign out_src[72]     = step_timing_output;
  assign out_src[73]     = zone_one_flag;
  assign out_src[74]     = zone_two_flag;
  assign out_src[75]     = zone_three_flag;
  assign out_src[79:76]  = 4'h0;
  assign out_src[80]     = serial_busy_output;
  assign out_src[127:81] = 47'h0;

  genvar k;
  generate
    for (k = 0; k < 6; k++)
    begin : g_out
      wire pick = ~out_code[k][7] & out_src[out_code[k][6:0]];
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          output_terminal[k] <= 1'b0;
        else
          output_terminal[k] <= pick;
      end

      property p_out_unused;
        (out_code[k] == 8'h00) |=> !output_terminal[k];
      endproperty
      a_out_unused: assert property (p_out_unused)
        else $error("unused output terminal asserted");

      property p_echo_start;
        (cfg_taken && out_code[k] == `ADIO_FN_START) |=>
          (output_terminal[k] == $past(func_in[4]));
      endproperty
      a_echo_start: assert property (p_echo_start)
        else $error("start response does not echo input");
    end
    for (t = 0; t < 8; t++)
    begin : g_in_chk
      property p_in_home;
        (input_terminal[t] && in_code[t] == `ADIO_FN_HOME) |-> func_in[3];
      endproperty
      a_in_home: assert property (p_in_home)
        else $error("assigned input did not raise its function");
    end
  endgenerate

  // switch values are taken once after reset so a knock mid-run is harmless
  logic [19:0] baud_dec;
  assign baud_dec =
    (rate_select_switch == 4'h0) ? `ADIO_BAUD_0 :
    (rate_select_switch == 4'h1) ? `ADIO_BAUD_1 :
    (rate_select_switch == 4'h2) ? `ADIO_BAUD_2 :
    (rate_select_switch == 4'h3) ? `ADIO_BAUD_3 :
    (rate_select_switch == 4'h4) ? `ADIO_BAUD_4 :
    (rate_select_switch == 4'h7) ? `ADIO_BAUD_7 : 20'd0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_taken   <= 1'b0;
      axis_number <= 5'h00;
      rate_code   <= `ADIO_RATE_FACTORY;
      baud_rate   <= `ADIO_BAUD_7;
      rate_valid  <= 1'b1;
      protocol    <= ADIO_PROTO_CONVERTER;
    end
    else if (!cfg_taken)
    begin
      cfg_taken   <= 1'b1;
      axis_number <= {function_dip_switch[0],
                      axis_rotary_switch};
      rate_code   <= rate_select_switch;
      baud_rate   <= baud_dec;
      rate_valid  <= baud_dec != 20'd0;
      protocol    <= adio_proto_t'(function_dip_switch[1]);
    end
  end

  // indicators, remote bits and the sticky link error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      supply_lamp        <= 1'b0;
      link_activity_lamp <= 1'b0;
      link_err           <= 1'b0;
      link_error_lamp    <= 1'b0;
      remote_bits        <= 16'h0000;
      blink_cnt          <= 23'h0;
      fault_lamp         <= 1'b0;
    end
    else
    begin
      supply_lamp        <= 1'b1;
      link_activity_lamp <= rx_active | tx_active;
      // a new error in the clearing cycle still wins
      link_err           <= comm_error_event
                            | (link_err & ~wr_err_clr);
      link_error_lamp    <= comm_error_event
                            | (link_err & ~wr_err_clr);
      if (wr_remote & wr_strb[0])
        remote_bits[7:0] <= wr_data[7:0];
      if (wr_remote & wr_strb[1])
        remote_bits[15:8] <= wr_data[15:8];
      if (!fault_output)
      begin
        blink_cnt  <= 23'h0;
        fault_lamp <= 1'b0;
      end
      else if (blink_cnt == BLINK_LAST)
      begin
        blink_cnt  <= 23'h0;
        fault_lamp <= ~fault_lamp;
      end
      else
        blink_cnt <= blink_cnt + 23'h1;
    end
  end

  sequence s_capture;
    !cfg_taken ##1 cfg_taken;
  endsequence
  sequence s_home_rise;
    !func_in[3] ##1 func_in[3];
  endsequence
  sequence s_start_rise;
    !func_in[4] ##1 func_in[4];
  endsequence
  sequence s_fclr_rise;
    !func_in[24] ##1 func_in[24];
  endsequence

  // the release edge still loads reset values, so terminal checks wait
  // for the capture cycle
  property p_home_pos;
    (cfg_taken && out_code[0] == `ADIO_FN_HOME_POS) |=>
      (output_terminal[0] == $past(home_position));
  endproperty
  a_home_pos: assert property (p_home_pos)
    else $error("home position output wrong");

  property p_end;
    (cfg_taken && out_code[1] == `ADIO_FN_END) |=>
      (output_terminal[1] == $past(move_done));
  endproperty
  a_end: assert property (p_end)
    else $error("move finished output wrong");

  property p_zone1;
    (cfg_taken && out_code[2] == `ADIO_FN_ZONE1) |=>
      (output_terminal[2] == $past(zone_one_flag));
  endproperty
  a_zone1: assert property (p_zone1)
    else $error("zone one output wrong");

  property p_ready;
    (cfg_taken && out_code[3] == `ADIO_FN_READY) |=>
      (output_terminal[3] == $past(ready_state));
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready output wrong");

  property p_caution;
    (cfg_taken && out_code[4] == `ADIO_FN_CAUTION) |=>
      (output_terminal[4] == $past(caution_output));
  endproperty
  a_caution: assert property (p_caution)
    else $error("warning output wrong");

  property p_fault_nc;
    (cfg_taken && out_code[5] == `ADIO_FN_FAULT) |=>
      (output_terminal[5] != $past(fault_output));
  endproperty
  a_fault_nc: assert property (p_fault_nc)
    else $error("alarm output not inverted");

  property p_rate;
    s_capture |-> (rate_valid == ($past(rate_select_switch) <= 4'h4 ||
                   $past(rate_select_switch) == 4'h7)) &&
                  ($past(rate_select_switch) != 4'h4 ||
                   baud_rate == `ADIO_BAUD_4);
  endproperty
  a_rate: assert property (p_rate)
    else $error("baud decode wrong");

  property p_axis_low;
    s_capture |-> (axis_number[3:0] == $past(axis_rotary_switch));
  endproperty
  a_axis_low: assert property (p_axis_low)
    else $error("axis number low bits wrong");

  property p_axis_ext;
    s_capture |-> (axis_number[4] == $past(function_dip_switch[0]));
  endproperty
  a_axis_ext: assert property (p_axis_ext)
    else $error("axis extend bit wrong");

  property p_proto;
    s_capture |-> (protocol == $past(function_dip_switch[1]));
  endproperty
  a_proto: assert property (p_proto)
    else $error("protocol select wrong");

  property p_cfg_hold;
    cfg_taken |=> $stable(axis_number) && $stable(baud_rate)
                  && $stable(protocol);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("switch settings changed in operation");

  property p_blink;
    (fault_output && blink_cnt == BLINK_LAST) |=>
      (fault_lamp != $past(fault_lamp));
  endproperty
  a_blink: assert property (p_blink)
    else $error("alarm lamp did not toggle");

  property p_activity;
    (rx_active || tx_active) |=> link_activity_lamp;
  endproperty
  a_activity: assert property (p_activity)
    else $error("activity lamp dark during traffic");

  property p_link_err;
    comm_error_event |=> link_error_lamp ##1 (link_error_lamp || $past(wr_err_clr));
  endproperty
  a_link_err: assert property (p_link_err)
    else $error("error lamp did not latch");

  property p_home;
    s_home_rise |=> home_req ##1 !home_req;
  endproperty
  a_home: assert property (p_home)
    else $error("homing request missing");

  property p_start;
    s_start_rise |=> start_req && data_select_bit0 == $past(func_in[48]);
  endproperty
  a_start: assert property (p_start)
    else $error("start request missing");

  property p_select;
    cfg_taken |=> {data_select_bit2, data_select_bit1, data_select_bit0}
             == $past(func_in[50:48]);
  endproperty
  a_select: assert property (p_select)
    else $error("data select bits wrong");

  property p_free;
    func_in[16] |=> motor_free;
  endproperty
  a_free: assert property (p_free)
    else $error("motor free missing");

  property p_halt;
    func_in[18] |=> halt_req;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt missing");

  property p_fclr;
    s_fclr_rise |=> fault_clear ##1 !fault_clear;
  endproperty
  a_fclr: assert property (p_fclr)
    else $error("alarm clear pulse wrong");

endmodule

/* File: verification/adio_host_model.sv */
// host controller model: drives input terminals and serial traffic
`timescale 1ns/10ps
module adio_host_model
(
  input  wire logic aclk,
  output logic [7:0] input_terminal,
  output logic       rx_active,
  output logic       tx_active
);
  initial {input_terminal, rx_active, tx_active} = '0;
  // levels move just after an edge and are held, as a plc output would
  task automatic drive(input logic [7:0] t, input logic rx);
    @(posedge aclk);
    input_terminal <= t;
    rx_active      <= rx;
    tx_active      <= rx;
  endtask
endmodule

/* File: verification/adio_tb_top.sv */
// bench for terminal mapping, switch decode and lamps
`timescale 1ns/10ps
`include "adio_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module adio_tb_top;
  import adio_pkg::*;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, err = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_v;
  logic [3:0]  wstrb = 4'hf, rot = 0, rate = 0, rc;
  logic [53:0] ifl;
  logic        rv;
  logic [1:0]  dip = 0;
  logic [5:0]  src = 0, output_terminal;
  logic [9:0]  misc = 0;
  logic [7:0]  input_terminal;
  logic [4:0]  axis_number;
  logic [19:0] baud_rate;
  logic awready, wready, bvalid, arready, rvalid, rx_active, tx_active;
  logic home_req, start_req, fault_clear, motor_free, halt_req, fault_lamp;
  logic data_select_bit0, data_select_bit1, data_select_bit2;
  logic link_activity_lamp, link_error_lamp;
  adio_resp_t  bresp, rresp, r;
  adio_proto_t protocol;
  int error_cnt = 0, checks = 0, cyc = 0, n;
  int bt[9] = '{9600, 19200, 38400, 57600, 115200, 0, 0, 625000, 0};
  always #25 aclk = ~aclk;
  adio_host_model host (.aclk, .input_terminal, .rx_active, .tx_active);
  adio_top #(.BLINK_HALF_CYC(4)) DUT (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .input_terminal, .output_terminal, .axis_rotary_switch(rot),
    .rate_select_switch(rate), .function_dip_switch(dip),
    .home_position(src[0]), .move_done(src[1]), .zone_one_flag(src[2]),
    .ready_state(src[3]), .caution_output(src[4]), .fault_output(src[5]),
    .moving_state(misc[0]), .zone_two_flag(misc[1]),
    .zone_three_flag(misc[2]), .torque_limit_output(misc[3]),
    .step_timing_output(misc[4]), .serial_busy_output(misc[5]),
    .limit_pos_sensor(misc[6]), .limit_neg_sensor(misc[7]),
    .home_sensor(misc[8]), .slit_sensor(misc[9]), .rx_active, .tx_active,
    .comm_error_event(err), .home_req, .start_req, .data_select_bit0,
    .data_select_bit1, .data_select_bit2, .data_select_high(), .motor_free,
    .halt_req, .fault_clear, .input_function_levels(ifl), .axis_number,
    .rate_code(rc), .baud_rate, .rate_valid(rv), .protocol, .supply_lamp(),
    .fault_lamp, .link_activity_lamp, .link_error_lamp);
  task automatic complete_run();
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd_v = rdata;
    rready <= 0;
  endtask
  task automatic t_switch();
    for (int i = 0; i < 9; i++)
    begin
      @(posedge aclk);
      aresetn <= 0; rate <= i[3:0]; rot <= 4'(i + 3); dip <= i[1:0];
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rot <= 4'h0; dip <= ~dip; rate <= 4'h7;
      repeat (2) @(posedge aclk);
      #1 `CHK(baud_rate, 20'(bt[i]))
      `CHK(axis_number, {i[0], 4'(i + 3)})
      `CHK(protocol, adio_proto_t'(i[1]))
      `CHK({rv, rc}, {1'(bt[i] != 0), i[3:0]})
    end
  endtask
  task automatic t_out();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge aclk) src <= 6'(1 << i);
      repeat (3) @(posedge aclk);
      #1 `CHK(output_terminal, 6'(1 << i) ^ 6'h20)
    end
  endtask
  task automatic t_in();
    host.drive(8'h7d, 0);
    @(posedge aclk) #1 `CHK(home_req, 1'b1)
    `CHK({data_select_bit2, data_select_bit1, data_select_bit0}, 3'h7)
    `CHK({motor_free, halt_req}, 2'h3)
    @(posedge aclk) #1 `CHK(home_req, 1'b0)
    host.drive(8'h82, 0);
    @(posedge aclk) #1 `CHK({start_req, fault_clear}, 2'h3)
  endtask
  task automatic t_reg();
    // out: home echo, start echo, limit sensor, unused, remote bit 0, unused
    wr(`ADIO_OFS_OUT_LO, 32'h003c_0403);
    wr(`ADIO_OFS_OUT_HI, 32'h0000_0020);
    wr(`ADIO_OFS_IN_LO, 32'h0000_0300);
    host.drive(8'h01, 0);
    src <= 6'h0f;
    repeat (3) @(posedge aclk);
    #1 `CHK(output_terminal, 6'h00)
    `CHK({home_req, ifl}, 55'h0)
    host.drive(8'h02, 0);
    misc <= 10'h040;
    wr(`ADIO_OFS_REMOTE, 32'h1);
    repeat (2) @(posedge aclk);
    #1 `CHK(output_terminal, 6'h15)
    `CHK(ifl, 54'h8)
    wr(8'h1c, 32'h0);
    `CHK(r, ADIO_RESP_SLVERR)
    rd(`ADIO_OFS_STATUS);
    `CHK(rd_v[13:0], 14'h1502)
  endtask
  task automatic t_lamp();
    host.drive(8'h00, 1);
    @(posedge aclk) err <= 1;
    @(posedge aclk) err <= 0;
    src <= 6'h20;
    repeat (2) @(posedge aclk);
    #1 `CHK({link_activity_lamp, link_error_lamp}, 2'h3)
    n = 0;
    repeat (20) @(posedge aclk) n += int'(fault_lamp);
    `CHK(n inside {[8:12]}, 1'b1)
    wr(`ADIO_OFS_LINK_ERR, 32'h1);
    #1 `CHK(link_error_lamp, 1'b0)
  endtask
  initial
  begin
    t_switch();
    t_out();
    t_in();
    t_reg();
    t_lamp();
    complete_run();
  end
endmodule
